// file: shared/sipa_pkg.sv
package sipa_pkg;
   localparam int unsigned NDS = 2;
   localparam int unsigned NWIRE = 4;
   localparam int unsigned AW = 8;
   localparam int unsigned NEV = 4;
   // Wire numbering A..D
   localparam logic [1:0] W_A = 2'h0;
   localparam logic [1:0] W_B = 2'h1;
   localparam logic [1:0] W_C = 2'h2;
   localparam logic [1:0] W_D = 2'h3;
   // Index 0 is switch port 2, index 1 is switch port 4
   localparam int unsigned DS_P2 = 0;
   localparam int unsigned DS_P4 = 1;
   localparam logic [1:0] P2_ROT = 2'h2;
   localparam logic [AW-1:0] OFF_CTRL0 = 8'h00;
   localparam logic [AW-1:0] OFF_CTRL1 = 8'h04;
   localparam logic [AW-1:0] OFF_LSTS0 = 8'h08;
   localparam logic [AW-1:0] OFF_LSTS1 = 8'h0c;
   localparam logic [AW-1:0] OFF_PST0 = 8'h10;
   localparam logic [AW-1:0] OFF_PST1 = 8'h14;
   localparam logic [AW-1:0] OFF_UST = 8'h18;
   localparam logic [AW-1:0] OFF_EVT = 8'h1c;
   localparam logic [AW-1:0] OFF_MASK = 8'h20;
   localparam int unsigned EV_ASSERT = 0;
   localparam int unsigned EV_DEASSERT = 1;
   localparam int unsigned EV_MSI = 2;
   localparam int unsigned EV_LINKDOWN = 3;
   localparam int unsigned LSTS_LBW = 0;
   localparam int unsigned LSTS_LABW = 1;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [NEV-1:0] MASK_RST = 4'h0;
   typedef struct packed {
      logic labw_ie;
      logic lbw_ie;
      logic legacy_irq_disable;
      logic msi_en;
   } sipa_ctrl_t;
   typedef struct packed {
      logic link_autonomous_bw_status;
      logic link_bw_mgmt_status;
   } sipa_lsts_t;
   typedef struct packed {
      logic valid;
      logic is_assert;
      logic [1:0] wire_idx;
   } sipa_vw_t;
   typedef struct packed {
      logic valid;
      logic port_sel;
   } sipa_msi_t;
endpackage

// file: design/sipa_top.sv
// What this block does
// R1: Upstream port 0 never originates INTx messages or MSIs of its own.
// R2: Downstream sources are hot-plug plus enabled link bandwidth status bits.
// R3: A downstream port signals its own interrupts only on wire INTA.
// R4: Unmasked assertion: MSI if enabled, else Assert_INTA unless disabled.
// R5: Unmasked negation: Deassert_INTA if MSI off and not disabled, else nothing.
// R6: Condition ends when every causing unmasked status bit is masked or cleared.
// R7: All downstream MSIs are routed to the upstream port.
// R8: Software must aim MSI addresses at the upstream port.
// R9: Each port keeps separate aggregated state for wires A, B, C, D.
// R10: Port state combines own interrupts with messages from its link partner.
// R11: Upstream state reports switch-wide aggregated level of each wire.
// R12: One Assert_INTx upstream per negated-to-asserted aggregate transition.
// R13: One Deassert_INTx upstream per asserted-to-negated aggregate transition.
// R14: No device-number swizzle on messages received by downstream ports.
// R15: Upstream A..D take port 2 C,D,A,B and port 4 A..D.
// R16: Mapped downstream wires include received and self-generated interrupts.
// R17: Link down negates all of a port's wires and updates upstream aggregate.
// R18: Upstream wire is the OR of downstream wires mapped onto it.
//
// Implementation choices: the APB slave port and the register addresses.
module sipa_top (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [sipa_pkg::AW-1:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [sipa_pkg::NDS-1:0] hp_irq_in,
   input wire logic [sipa_pkg::NDS-1:0] lbw_evt_in,
   input wire logic [sipa_pkg::NDS-1:0] labw_evt_in,
   input wire logic [sipa_pkg::NDS-1:0] dl_up_in,
   input wire sipa_pkg::sipa_vw_t rx_vw_in [sipa_pkg::NDS],
   output sipa_pkg::sipa_vw_t up_msg_out,
   input wire logic up_msg_ready_in,
   output sipa_pkg::sipa_msi_t msi_out,
   input wire logic msi_ready_in,
   output logic irq_out
);
   localparam int unsigned NDS = sipa_pkg::NDS;
   localparam int unsigned NW = sipa_pkg::NWIRE;

   function automatic logic [3:0] map_up(input logic [3:0] p2, input logic [3:0] p4);
      logic [3:0] r;
      r = '0;
      for (int w = 0; w < NW; w++) begin
         r[w] = p2[2'(w + int'(sipa_pkg::P2_ROT))] | p4[w]; // R15 R18
      end
      return r;
   endfunction

   function automatic logic hit(input logic [sipa_pkg::AW-1:0] a,
                                input logic [sipa_pkg::AW-1:0] off);
      return a == off;
   endfunction

   // Bus state
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic wr_en, acc;
   // Port state
   sipa_pkg::sipa_ctrl_t ctrl_q [NDS];
   sipa_pkg::sipa_ctrl_t ctrl_d [NDS];
   sipa_pkg::sipa_lsts_t lsts_q [NDS];
   sipa_pkg::sipa_lsts_t lsts_d [NDS];
   logic [NDS-1:0] cond, cond_q, rise, fall, own_q, own_d, dl_q;
   logic [NDS-1:0] msi_pend_q, msi_pend_d;
   logic [NW-1:0] rxw_q [NDS];
   logic [NW-1:0] rxw_d [NDS];
   logic [NW-1:0] pst [NDS];
   logic [NW-1:0] ust_q, ust_d, sent_q, sent_d;
   sipa_pkg::sipa_vw_t msg_q, msg_d;
   sipa_pkg::sipa_msi_t msi_q, msi_d;
   logic [sipa_pkg::NEV-1:0] evt_q, evt_d, mask_q, mask_d, ev_set;
   logic irq_q, irq_d;

   assign acc = psel_in & penable_in & pready_q;
   assign wr_en = acc & pwrite_in;

   // Port source logic
   always_comb begin
      for (int p = 0; p < NDS; p++) begin
         cond[p] = hp_irq_in[p]
            | (lsts_q[p].link_bw_mgmt_status & ctrl_q[p].lbw_ie)
            | (lsts_q[p].link_autonomous_bw_status & ctrl_q[p].labw_ie); // R2 R6
         rise[p] = cond[p] & ~cond_q[p];
         fall[p] = ~cond[p] & cond_q[p];
         ctrl_d[p] = ctrl_q[p];
         if (wr_en && hit(paddr_in, (p == 0) ? sipa_pkg::OFF_CTRL0 : sipa_pkg::OFF_CTRL1)) begin
            ctrl_d[p] = sipa_pkg::sipa_ctrl_t'(pwdata_in[3:0]);
         end
         lsts_d[p] = lsts_q[p];
         if (wr_en && hit(paddr_in, (p == 0) ? sipa_pkg::OFF_LSTS0 : sipa_pkg::OFF_LSTS1)) begin
            lsts_d[p].link_bw_mgmt_status = lsts_q[p].link_bw_mgmt_status
               & ~pwdata_in[sipa_pkg::LSTS_LBW];
            lsts_d[p].link_autonomous_bw_status = lsts_q[p].link_autonomous_bw_status
               & ~pwdata_in[sipa_pkg::LSTS_LABW];
         end
         // Set beats a same-cycle clear
         lsts_d[p].link_bw_mgmt_status = lsts_d[p].link_bw_mgmt_status | lbw_evt_in[p];
         lsts_d[p].link_autonomous_bw_status = lsts_d[p].link_autonomous_bw_status
            | labw_evt_in[p];
         // Own INTA; edges only, so a disable during assertion leaves it standing
         own_d[p] = own_q[p];
         if (!dl_up_in[p]) begin
            own_d[p] = 1'b0; // R17
         end else if (!ctrl_q[p].msi_en && !ctrl_q[p].legacy_irq_disable) begin
            if (rise[p]) begin
               own_d[p] = 1'b1; // R4
            end else if (fall[p]) begin
               own_d[p] = 1'b0; // R5
            end
         end
         // Partner messages kept per wire, unswizzled
         rxw_d[p] = rxw_q[p];
         if (!dl_up_in[p]) begin
            rxw_d[p] = '0; // R17
         end else if (rx_vw_in[p].valid) begin
            rxw_d[p][rx_vw_in[p].wire_idx] = rx_vw_in[p].is_assert; // R9 R14
         end
         pst[p] = rxw_q[p] | {3'h0, own_q[p]}; // R3 R10 R16
      end
   end

   // MSI issue; ports share one upstream path
   always_comb begin
      msi_pend_d = msi_pend_q;
      msi_d = msi_q;
      if (msi_q.valid && msi_ready_in) begin
         msi_d.valid = 1'b0;
      end
      if (!msi_d.valid) begin
         for (int p = NDS - 1; p >= 0; p--) begin
            if (msi_pend_q[p]) begin
               msi_d.valid = 1'b1; // R7
               msi_d.port_sel = 1'(p);
            end
         end
         if (msi_d.valid) begin
            msi_pend_d[msi_d.port_sel] = 1'b0;
         end
      end
      for (int p = 0; p < NDS; p++) begin
         if (rise[p] && ctrl_q[p].msi_en) begin
            msi_pend_d[p] = 1'b1; // R4
         end
      end
   end

   // Upstream aggregate and messages; port 0 has no sources of its own
   always_comb begin
      ust_d = map_up(pst[sipa_pkg::DS_P2], pst[sipa_pkg::DS_P4]); // R1 R11
      sent_d = sent_q;
      msg_d = msg_q;
      if (msg_q.valid && up_msg_ready_in) begin
         msg_d.valid = 1'b0;
      end
      if (!msg_d.valid) begin
         for (int w = NW - 1; w >= 0; w--) begin
            if (ust_q[w] != sent_q[w]) begin
               msg_d.valid = 1'b1;
               msg_d.wire_idx = 2'(w);
               msg_d.is_assert = ust_q[w]; // R12 R13
            end
         end
         if (msg_d.valid) begin
            sent_d[msg_d.wire_idx] = msg_d.is_assert;
         end
      end
   end

   // Event status, mask and interrupt
   always_comb begin
      ev_set = '0;
      ev_set[sipa_pkg::EV_ASSERT] = msg_d.valid & ~msg_q.valid & msg_d.is_assert;
      ev_set[sipa_pkg::EV_DEASSERT] = msg_d.valid & ~msg_q.valid & ~msg_d.is_assert;
      ev_set[sipa_pkg::EV_MSI] = msi_d.valid & ~msi_q.valid;
      ev_set[sipa_pkg::EV_LINKDOWN] = |(dl_q & ~dl_up_in);
      ev_set[sipa_pkg::EV_ASSERT] = ev_set[sipa_pkg::EV_ASSERT]
         | (msg_q.valid & up_msg_ready_in & msg_d.valid & msg_d.is_assert);
      ev_set[sipa_pkg::EV_DEASSERT] = ev_set[sipa_pkg::EV_DEASSERT]
         | (msg_q.valid & up_msg_ready_in & msg_d.valid & ~msg_d.is_assert);
      ev_set[sipa_pkg::EV_MSI] = ev_set[sipa_pkg::EV_MSI]
         | (msi_q.valid & msi_ready_in & msi_d.valid);
      evt_d = evt_q;
      mask_d = mask_q;
      if (wr_en && hit(paddr_in, sipa_pkg::OFF_EVT)) begin
         evt_d = evt_q & ~pwdata_in[sipa_pkg::NEV-1:0];
      end
      if (wr_en && hit(paddr_in, sipa_pkg::OFF_MASK)) begin
         mask_d = pwdata_in[sipa_pkg::NEV-1:0];
      end
      evt_d = evt_d | ev_set;
      irq_d = |(evt_d & mask_d);
   end

   // APB slave; one wait state, so pready comes from a flop
   always_comb begin
      pready_d = psel_in & penable_in & ~pready_q;
      prdata_d = '0;
      pslverr_d = 1'b0;
      if (pready_d) begin
         case (paddr_in)
            sipa_pkg::OFF_CTRL0: prdata_d = {28'h0, ctrl_q[0]};
            sipa_pkg::OFF_CTRL1: prdata_d = {28'h0, ctrl_q[1]};
            sipa_pkg::OFF_LSTS0: prdata_d = {30'h0, lsts_q[0]};
            sipa_pkg::OFF_LSTS1: prdata_d = {30'h0, lsts_q[1]};
            sipa_pkg::OFF_PST0: prdata_d = {28'h0, pst[0]};
            sipa_pkg::OFF_PST1: prdata_d = {28'h0, pst[1]};
            sipa_pkg::OFF_UST: prdata_d = {28'h0, ust_q};
            sipa_pkg::OFF_EVT: prdata_d = {28'h0, evt_q};
            sipa_pkg::OFF_MASK: prdata_d = {28'h0, mask_q};
            default: pslverr_d = 1'b1;
         endcase
         if (pwrite_in) begin
            prdata_d = '0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
         for (int p = 0; p < NDS; p++) begin
            ctrl_q[p] <= sipa_pkg::CTRL_RST;
            lsts_q[p] <= '0;
            rxw_q[p] <= '0;
         end
         cond_q <= '0;
         own_q <= '0;
         dl_q <= '0;
         msi_pend_q <= '0;
         msi_q <= '0;
         ust_q <= '0;
         sent_q <= '0;
         msg_q <= '0;
         evt_q <= '0;
         mask_q <= sipa_pkg::MASK_RST;
         irq_q <= 1'b0;
      end else begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         for (int p = 0; p < NDS; p++) begin
            ctrl_q[p] <= ctrl_d[p];
            lsts_q[p] <= lsts_d[p];
            rxw_q[p] <= rxw_d[p];
         end
         cond_q <= cond;
         own_q <= own_d;
         dl_q <= dl_up_in;
         msi_pend_q <= msi_pend_d;
         msi_q <= msi_d;
         ust_q <= ust_d;
         sent_q <= sent_d;
         msg_q <= msg_d;
         evt_q <= evt_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign up_msg_out = msg_q;
   assign msi_out = msi_q;
   assign irq_out = irq_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   for (genvar g = 0; g < NDS; g++) begin : g_chk
      property p_own_assert;
         rise[g] && dl_up_in[g] && !ctrl_q[g].msi_en && !ctrl_q[g].legacy_irq_disable
            |=> own_q[g];
      endproperty
      a_own_assert: assert property (p_own_assert) else $error("INTA not raised"); // R4
      property p_msi_req;
         rise[g] && ctrl_q[g].msi_en
            |=> msi_pend_q[g] || (msi_q.valid && msi_q.port_sel == 1'(g));
      endproperty
      a_msi_req: assert property (p_msi_req) else $error("MSI not requested"); // R4
      property p_own_deassert;
         fall[g] && dl_up_in[g] && !ctrl_q[g].msi_en && !ctrl_q[g].legacy_irq_disable
            |=> !own_q[g];
      endproperty
      a_own_deassert: assert property (p_own_deassert) else $error("INTA not lowered"); // R5
      property p_disable_hold;
         ctrl_q[g].legacy_irq_disable && dl_up_in[g] |=> $stable(own_q[g]);
      endproperty
      a_disable_hold: assert property (p_disable_hold) else $error("INTA moved while off"); // R5
      property p_linkdown;
         !dl_up_in[g] |=> pst[g] == '0;
      endproperty
      a_linkdown: assert property (p_linkdown) else $error("Wires kept over link down"); // R17
      property p_rx_take;
         rx_vw_in[g].valid && dl_up_in[g]
            |=> rxw_q[g][$past(rx_vw_in[g].wire_idx)] == $past(rx_vw_in[g].is_assert);
      endproperty
      a_rx_take: assert property (p_rx_take) else $error("Partner message lost"); // R9 R14
      property p_own_wire_a;
         own_q[g] |-> pst[g][sipa_pkg::W_A];
      endproperty
      a_own_wire_a: assert property (p_own_wire_a) else $error("Own INTA not on A"); // R3 R16
      property p_linkdown_evt;
         dl_q[g] && !dl_up_in[g] |=> evt_q[sipa_pkg::EV_LINKDOWN];
      endproperty
      a_linkdown_evt: assert property (p_linkdown_evt) else $error("Link down not logged"); // R17
   end

   // Expected map spelled out per wire, independent of the map function
   property p_map;
      1'b1 |=> ust_q[sipa_pkg::W_A] == ($past(pst[sipa_pkg::DS_P2][sipa_pkg::W_C])
            | $past(pst[sipa_pkg::DS_P4][sipa_pkg::W_A]))
         && ust_q[sipa_pkg::W_B] == ($past(pst[sipa_pkg::DS_P2][sipa_pkg::W_D])
            | $past(pst[sipa_pkg::DS_P4][sipa_pkg::W_B]))
         && ust_q[sipa_pkg::W_C] == ($past(pst[sipa_pkg::DS_P2][sipa_pkg::W_A])
            | $past(pst[sipa_pkg::DS_P4][sipa_pkg::W_C]))
         && ust_q[sipa_pkg::W_D] == ($past(pst[sipa_pkg::DS_P2][sipa_pkg::W_B])
            | $past(pst[sipa_pkg::DS_P4][sipa_pkg::W_D]));
   endproperty
   a_map: assert property (p_map) else $error("Upstream map wrong"); // R15

   property p_msi_hold;
      msi_q.valid && !msi_ready_in |=> msi_q.valid && $stable(msi_q);
   endproperty
   a_msi_hold: assert property (p_msi_hold) else $error("MSI dropped"); // R7

   sequence s_pending;
      ust_q != sent_q && !msg_q.valid;
   endsequence
   sequence s_issued;
      msg_q.valid && sent_q[msg_q.wire_idx] == msg_q.is_assert;
   endsequence
   property p_msg_issue;
      s_pending |=> s_issued;
   endproperty
   a_msg_issue: assert property (p_msg_issue) else $error("Transition not sent"); // R12 R13

   property p_msg_hold;
      msg_q.valid && !up_msg_ready_in |=> msg_q.valid && $stable(msg_q);
   endproperty
   a_msg_hold: assert property (p_msg_hold) else $error("Message dropped"); // R12

   property p_irq;
      1'b1 |=> irq_out == |(evt_q & mask_q);
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt line wrong");
endmodule

// file: tb/sipa_root_model.sv
module sipa_root_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic slow_in,
   input wire sipa_pkg::sipa_vw_t msg_in,
   output logic msg_ready_out,
   input wire sipa_pkg::sipa_msi_t msi_in,
   output logic msi_ready_out,
   output logic [7:0] n_msg_out,
   output sipa_pkg::sipa_vw_t last_msg_out,
   output logic [7:0] n_msi_out,
   output logic last_port_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_q;
   // Slow mode takes one cycle in four, so held requests get stretched
   assign msg_ready_out = !slow_in || (ph_q == 2'h3);
   assign msi_ready_out = msg_ready_out;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ph_q <= 2'h0;
         n_msg_out <= 8'h00;
         last_msg_out <= '0;
         n_msi_out <= 8'h00;
         last_port_out <= 1'b0;
      end else begin
         ph_q <= ph_q + 2'h1;
         if (msg_in.valid && msg_ready_out) begin
            n_msg_out <= n_msg_out + 8'h01;
            last_msg_out <= msg_in;
         end
         if (msi_in.valid && msi_ready_out) begin
            n_msi_out <= n_msi_out + 8'h01;
            last_port_out <= msi_in.port_sel;
         end
      end
   end
endmodule

// file: tb/switch_port_intx_msi_aggregation_test.sv
module switch_port_intx_msi_aggregation_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, up_rdy, msi_rdy, irq, slow;
   logic last_port, err;
   logic [7:0] paddr, n_msg, n_msi, seen;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] hp_irq, lbw_evt, labw_evt, dl_up;
   sipa_pkg::sipa_vw_t rx_vw [sipa_pkg::NDS];
   sipa_pkg::sipa_vw_t up_msg, last_msg;
   sipa_pkg::sipa_msi_t msi;
   int mismatches, n_checks;
   sipa_top dut (.ref_clk_in(ref_clk), .rstn_in(rstn), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .hp_irq_in(hp_irq), .lbw_evt_in(lbw_evt),
      .labw_evt_in(labw_evt), .dl_up_in(dl_up), .rx_vw_in(rx_vw), .up_msg_out(up_msg),
      .up_msg_ready_in(up_rdy), .msi_out(msi), .msi_ready_in(msi_rdy), .irq_out(irq));
   sipa_root_model root (.clk_in(ref_clk), .rstn_in(rstn), .slow_in(slow), .msg_in(up_msg),
      .msg_ready_out(up_rdy), .msi_in(msi), .msi_ready_out(msi_rdy), .n_msg_out(n_msg),
      .last_msg_out(last_msg), .n_msi_out(n_msi), .last_port_out(last_port));
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task hang();
      mismatches++;
      summarize();
   endtask
   // Request held until pready is sampled high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task rx(input int p, input logic a, input logic [1:0] w);
      @(posedge ref_clk);
      rx_vw[p] <= '{valid: 1'b1, is_assert: a, wire_idx: w};
      @(posedge ref_clk);
      rx_vw[p] <= '0;
   endtask
   task quiet();
      repeat (12) @(posedge ref_clk);
      chk(n_msg, seen);
   endtask
   // Exactly one message, then silence
   task wmsg(input logic a, input logic [1:0] w);
      int i;
      for (i = 0; i < 100 && n_msg === seen; i++) @(posedge ref_clk);
      if (i == 100) hang();
      seen = seen + 8'h01;
      chk({last_msg.is_assert, last_msg.wire_idx}, {a, w});
      quiet();
   endtask
   task t_regs();
      rdc(sipa_pkg::OFF_CTRL0, 32'h0);
      rdc(sipa_pkg::OFF_MASK, 32'h0);
      rdc(sipa_pkg::OFF_UST, 32'h0);
      rdc(8'hfc, 32'h0);
      chk(err, 1'b1);
      wr(sipa_pkg::OFF_MASK, 32'h5);
      rdc(sipa_pkg::OFF_MASK, 32'h5);
      wr(sipa_pkg::OFF_MASK, 32'h0);
      $display("test regs done");
   endtask
   task t_map();
      rx(1, 1'b1, sipa_pkg::W_A);
      wmsg(1'b1, sipa_pkg::W_A);
      rdc(sipa_pkg::OFF_PST1, 32'h1);
      rdc(sipa_pkg::OFF_UST, 32'h1);
      rx(0, 1'b1, sipa_pkg::W_C);
      quiet();
      rx(1, 1'b0, sipa_pkg::W_A);
      quiet();
      rdc(sipa_pkg::OFF_PST0, 32'h4);
      rx(0, 1'b0, sipa_pkg::W_C);
      wmsg(1'b0, sipa_pkg::W_A);
      rx(0, 1'b1, sipa_pkg::W_B);
      wmsg(1'b1, sipa_pkg::W_D);
      rx(0, 1'b0, sipa_pkg::W_B);
      wmsg(1'b0, sipa_pkg::W_D);
      $display("test map done");
   endtask
   task t_own();
      slow <= 1'b1;
      hp_irq[0] <= 1'b1;
      wmsg(1'b1, sipa_pkg::W_C);
      rdc(sipa_pkg::OFF_PST0, 32'h1);
      hp_irq[0] <= 1'b0;
      wmsg(1'b0, sipa_pkg::W_C);
      slow <= 1'b0;
      wr(sipa_pkg::OFF_CTRL1, 32'h4);
      @(posedge ref_clk);
      lbw_evt[1] <= 1'b1;
      @(posedge ref_clk);
      lbw_evt[1] <= 1'b0;
      wmsg(1'b1, sipa_pkg::W_A);
      wr(sipa_pkg::OFF_LSTS1, 32'h1);
      wmsg(1'b0, sipa_pkg::W_A);
      @(posedge ref_clk);
      labw_evt[1] <= 1'b1;
      @(posedge ref_clk);
      labw_evt[1] <= 1'b0;
      quiet();
      rdc(sipa_pkg::OFF_LSTS1, 32'h2);
      wr(sipa_pkg::OFF_CTRL1, 32'h8);
      wmsg(1'b1, sipa_pkg::W_A);
      wr(sipa_pkg::OFF_CTRL1, 32'h0);
      wmsg(1'b0, sipa_pkg::W_A);
      wr(sipa_pkg::OFF_LSTS1, 32'h2);
      $display("test own done");
   endtask
   task t_msi();
      int i;
      wr(sipa_pkg::OFF_CTRL1, 32'h1);
      hp_irq[1] <= 1'b1;
      for (i = 0; i < 50 && n_msi === 8'h00; i++) @(posedge ref_clk);
      if (i == 50) hang();
      chk(last_port, 1'b1);
      chk(n_msi, 8'h01);
      hp_irq[1] <= 1'b0;
      quiet();
      wr(sipa_pkg::OFF_CTRL1, 32'h2);
      hp_irq[1] <= 1'b1;
      quiet();
      hp_irq[1] <= 1'b0;
      quiet();
      chk(n_msi, 8'h01);
      wr(sipa_pkg::OFF_CTRL1, 32'h0);
      wr(sipa_pkg::OFF_CTRL0, 32'h1);
      hp_irq[0] <= 1'b1;
      for (i = 0; i < 50 && n_msi === 8'h01; i++) @(posedge ref_clk);
      if (i == 50) hang();
      chk(last_port, 1'b0);
      chk(n_msi, 8'h02);
      hp_irq[0] <= 1'b0;
      quiet();
      wr(sipa_pkg::OFF_CTRL0, 32'h0);
      $display("test msi done");
   endtask
   task t_link();
      rx(1, 1'b1, sipa_pkg::W_B);
      wmsg(1'b1, sipa_pkg::W_B);
      dl_up[1] <= 1'b0;
      wmsg(1'b0, sipa_pkg::W_B);
      rdc(sipa_pkg::OFF_PST1, 32'h0);
      rdc(sipa_pkg::OFF_EVT, 32'hf);
      dl_up[1] <= 1'b1;
      $display("test link done");
   endtask
   task t_irq();
      wr(sipa_pkg::OFF_EVT, 32'hf);
      wr(sipa_pkg::OFF_MASK, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'b0);
      rx(1, 1'b1, sipa_pkg::W_D);
      wmsg(1'b1, sipa_pkg::W_D);
      chk(irq, 1'b1);
      wr(sipa_pkg::OFF_EVT, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'b0);
      rx(1, 1'b0, sipa_pkg::W_D);
      wmsg(1'b0, sipa_pkg::W_D);
      rdc(sipa_pkg::OFF_EVT, 32'h2);
      chk(irq, 1'b0);
      $display("test irq done");
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      rstn = 1'b0;
      {psel, penable, pwrite, slow} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hp_irq = 2'h0;
      lbw_evt = 2'h0;
      labw_evt = 2'h0;
      dl_up = 2'h3;
      rx_vw[0] = '0;
      rx_vw[1] = '0;
      seen = 8'h00;
      mismatches = 0;
      n_checks = 0;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_map();
      t_own();
      t_msi();
      t_link();
      t_irq();
      summarize();
   end
endmodule
